/* File: dual_rtc.sv */
// Function
// - seconds counter divides its 32 kHz source by 32768 and counts seconds
// - flexible counter prescaler is any power of two, exponent 0 to 15
// - seconds from crystal; flexible from crystal or oscillator by select
// - seconds counter has one absolute non-repeating alarm in seconds
// - flexible alarm resolves one flexible count unit of 2^exponent source cycles
// - flexible counter has absolute alarm and periodic alarm every 60 units
// - four strobe channels, programmable period and duty, 0.25 Hz-16.384 kHz
// - each strobe pulses its pin from a target flexible count
// - strobes keep running in active, flexi and hibernate modes
// - a transition on a capture input latches the flexible count
// - a capture can wake the chip and raise an interrupt
// - the capture holds the exact source cycle of the event
// - each strobe owns three sense inputs sampled by its own pulse
// - each strobe can interrupt on activity of its sampled inputs
// - wake can be limited to a programmed pattern on sense inputs
// - the seconds alarm can wake the chip from shutdown when enabled
`timescale 1ns/1ps

module dual_rtc
  import rtc_pkg::*;
(
  // system
  input  wire logic              clk,
  input  wire logic              nrst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // low-frequency sources, sampled as data
  input  wire logic              low_freq_crystal,
  input  wire logic              low_freq_oscillator,
  // external sensor pins
  input  wire logic [NCAP-1:0]   cap_in,
  input  wire logic [NCH*NSENSE-1:0] sense_in,
  output logic      [NCH-1:0]    strobe_out,
  // to the processor and power control
  output logic                   irq,
  output logic                   wake
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]              rst_sync_r;
  logic                    rst_n;
  logic [1:0]              xtal_s_r, osc_s_r;
  logic                    xtal_d_r, osc_d_r;
  logic [NCAP-1:0]         cap_s1_r, cap_s2_r, cap_d_r;
  logic [NCH*NSENSE-1:0]   sense_s1_r, sense_s2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // first stages feed only the second stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_s_r   <= '0;
      osc_s_r    <= '0;
      xtal_d_r   <= 1'b0;
      osc_d_r    <= 1'b0;
      cap_s1_r   <= '0;
      cap_s2_r   <= '0;
      cap_d_r    <= '0;
      sense_s1_r <= '0;
      sense_s2_r <= '0;
    end else begin
      xtal_s_r   <= {xtal_s_r[0], low_freq_crystal};
      osc_s_r    <= {osc_s_r[0], low_freq_oscillator};
      xtal_d_r   <= xtal_s_r[1];
      osc_d_r    <= osc_s_r[1];
      cap_s1_r   <= cap_in;
      cap_s2_r   <= cap_s1_r;
      cap_d_r    <= cap_s2_r;
      sense_s1_r <= sense_in;
      sense_s2_r <= sense_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // source ticks
  // ----------------------------------------------------------------
  ctrl_type ctrl_r;
  logic     xtal_tick, osc_tick, flex_src_tick;

  assign xtal_tick = xtal_s_r[1] & ~xtal_d_r;
  assign osc_tick  = osc_s_r[1] & ~osc_d_r;
  assign flex_src_tick = ctrl_r.src_osc ? osc_tick : xtal_tick;

  // ----------------------------------------------------------------
  // counters, alarms, capture, status, registers
  // ----------------------------------------------------------------
  logic [14:0]  sec_div_r, sec_div_nxt;
  logic [31:0]  sec_cnt_r, sec_cnt_nxt, sec_alm_r, sec_alm_nxt;
  logic [14:0]  flex_pre_r, flex_pre_nxt, frac_mask;
  logic [31:0]  flex_cnt_r, flex_cnt_nxt, flex_alm_r, flex_alm_nxt;
  logic [5:0]   per_cnt_r, per_cnt_nxt;
  logic [31:0]  cap_cnt_r, cap_cnt_nxt;
  logic [14:0]  cap_frac_r, cap_frac_nxt;
  logic [ST_W-1:0] st_r, st_nxt, st_set, ien_r, ien_nxt, wen_r, wen_nxt;
  ctrl_type     ctrl_nxt;
  strobe_cfg_type  scfg_r [NCH];
  strobe_cfg_type  scfg_nxt [NCH];
  logic [31:0]     tgt_r [NCH];
  logic [31:0]     tgt_nxt [NCH];
  logic [PER_W-1:0] per_r [NCH];
  logic [PER_W-1:0] per_nxt [NCH];
  logic [PER_W-1:0] hi_r [NCH];
  logic [PER_W-1:0] hi_nxt [NCH];
  logic [NCH-1:0]  act_set, pat_set;
  logic         sec_tick, flex_tick, wr_en, acc, mapped;
  logic [31:0]  rdata;
  logic [31:0]  prdata_nxt;
  logic         pready_nxt, pslverr_nxt, irq_nxt, wake_nxt;
  logic [1:0]   ch_sel;
  logic         is_ch;

  assign frac_mask = ~(FRAC_ALL << ctrl_r.presc_exp);
  assign flex_tick = flex_src_tick & ctrl_r.flex_en
                   & ((flex_pre_r & frac_mask) == frac_mask);
  assign sec_tick  = xtal_tick & ctrl_r.sec_en & (sec_div_r == SEC_DIV_LAST);

  assign acc    = psel & penable;
  assign wr_en  = acc & pready & pwrite;
  assign ch_sel = paddr[5:4];
  assign is_ch  = (paddr[7:6] == CH_PAGE);

  always_comb begin
    // counting
    sec_div_nxt  = sec_div_r;
    sec_cnt_nxt  = sec_cnt_r;
    flex_pre_nxt = flex_pre_r;
    flex_cnt_nxt = flex_cnt_r;
    per_cnt_nxt  = per_cnt_r;
    cap_cnt_nxt  = cap_cnt_r;
    cap_frac_nxt = cap_frac_r;
    st_set       = '0;
    if (xtal_tick && ctrl_r.sec_en) begin
      sec_div_nxt = 15'(sec_div_r + 15'h1);
    end
    if (sec_tick) begin
      sec_cnt_nxt = sec_cnt_r + 32'h1;
      st_set[ST_SEC] = ctrl_r.sec_alarm_en
                     & (sec_cnt_nxt == sec_alm_r);
    end
    if (flex_src_tick && ctrl_r.flex_en) begin
      flex_pre_nxt = 15'(flex_pre_r + 15'h1);
    end
    if (flex_tick) begin
      flex_cnt_nxt = flex_cnt_r + 32'h1;
      // exponent 0 gives one unit per source cycle
      st_set[ST_FLEX] = ctrl_r.flex_alarm_en
                      & (flex_cnt_nxt == flex_alm_r);
      if (ctrl_r.periodic_en) begin
        per_cnt_nxt = (per_cnt_r == PERIODIC_LAST) ? 6'h0
                    : 6'(per_cnt_r + 6'h1);
        st_set[ST_PER] = (per_cnt_r == PERIODIC_LAST);
      end
    end
    if (ctrl_r.cap_en && (cap_s2_r != cap_d_r)) begin
      cap_cnt_nxt  = flex_cnt_r;
      cap_frac_nxt = flex_pre_r & frac_mask;
      st_set[ST_CAP] = 1'b1;
    end
    st_set[ST_ACT +: NCH] = act_set;
    st_set[ST_PAT +: NCH] = pat_set;

    // register writes
    ctrl_nxt    = ctrl_r;
    sec_alm_nxt = sec_alm_r;
    flex_alm_nxt = flex_alm_r;
    ien_nxt     = ien_r;
    wen_nxt     = wen_r;
    st_nxt      = st_r;
    for (int i = 0; i < NCH; i++) begin
      scfg_nxt[i] = scfg_r[i];
      tgt_nxt[i]  = tgt_r[i];
      per_nxt[i]  = per_r[i];
      hi_nxt[i]   = hi_r[i];
    end
    if (wr_en) begin
      if (is_ch) begin
        unique case (paddr[3:2])
          SUB_CFG:    scfg_nxt[ch_sel] = pwdata[$bits(strobe_cfg_type)-1:0];
          SUB_TARGET: tgt_nxt[ch_sel]  = pwdata;
          SUB_PERIOD: per_nxt[ch_sel]  = pwdata[PER_W-1:0];
          SUB_HIGH:   hi_nxt[ch_sel]   = pwdata[PER_W-1:0];
        endcase
      end else begin
        case (paddr)
          OFS_CTRL:     ctrl_nxt     = pwdata[$bits(ctrl_type)-1:0];
          OFS_SEC_CNT:  sec_cnt_nxt  = pwdata;
          OFS_SEC_ALM:  sec_alm_nxt  = pwdata;
          OFS_FLEX_CNT: flex_cnt_nxt = pwdata;
          OFS_FLEX_ALM: flex_alm_nxt = pwdata;
          OFS_IRQ_EN:   ien_nxt      = pwdata[ST_W-1:0];
          OFS_WAKE_EN:  wen_nxt      = pwdata[ST_W-1:0];
          OFS_CLEAR:    st_nxt       = st_r & ~pwdata[ST_W-1:0];
          default:      st_nxt       = st_r;
        endcase
      end
    end
    // a hardware event in the clearing cycle survives
    st_nxt  = st_nxt | st_set;
    irq_nxt = |(st_r & ien_r);
    wake_nxt = |(st_r & wen_r);
  end

  // ----------------------------------------------------------------
  // apb answer: one wait state, data registered with pready
  // ----------------------------------------------------------------
  always_comb begin
    rdata  = 32'h0;
    mapped = 1'b1;
    if (is_ch) begin
      unique case (paddr[3:2])
        SUB_CFG:    rdata = 32'(scfg_r[ch_sel]);
        SUB_TARGET: rdata = tgt_r[ch_sel];
        SUB_PERIOD: rdata = 32'(per_r[ch_sel]);
        SUB_HIGH:   rdata = 32'(hi_r[ch_sel]);
      endcase
    end else begin
      case (paddr)
        OFS_CTRL:     rdata = 32'(ctrl_r);
        OFS_SEC_CNT:  rdata = sec_cnt_r;
        OFS_SEC_ALM:  rdata = sec_alm_r;
        OFS_FLEX_CNT: rdata = flex_cnt_r;
        OFS_FLEX_ALM: rdata = flex_alm_r;
        OFS_CAP_CNT:  rdata = cap_cnt_r;
        OFS_CAP_FRAC: rdata = 32'(cap_frac_r);
        OFS_STATUS:   rdata = 32'(st_r);
        OFS_CLEAR:    rdata = 32'h0;
        OFS_IRQ_EN:   rdata = 32'(ien_r);
        OFS_WAKE_EN:  rdata = 32'(wen_r);
        OFS_PER_CNT:  rdata = 32'(per_cnt_r);
        default:      mapped = 1'b0;
      endcase
    end
    pready_nxt  = acc & ~pready;
    pslverr_nxt = acc & ~pready & ~mapped;
    prdata_nxt  = (acc & ~pready & ~pwrite & mapped) ? rdata : 32'h0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_div_r  <= '0;
      sec_cnt_r  <= '0;
      sec_alm_r  <= '0;
      flex_pre_r <= '0;
      flex_cnt_r <= '0;
      flex_alm_r <= '0;
      per_cnt_r  <= '0;
      cap_cnt_r  <= '0;
      cap_frac_r <= '0;
      st_r       <= '0;
      ien_r      <= '0;
      wen_r      <= '0;
      ctrl_r     <= CTRL_RST;
      for (int i = 0; i < NCH; i++) begin
        scfg_r[i] <= SCFG_RST;
        tgt_r[i]  <= '0;
        per_r[i]  <= PERIOD_RST;
        hi_r[i]   <= HIGH_RST;
      end
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
      wake       <= 1'b0;
    end else begin
      sec_div_r  <= sec_div_nxt;
      sec_cnt_r  <= sec_cnt_nxt;
      sec_alm_r  <= sec_alm_nxt;
      flex_pre_r <= flex_pre_nxt;
      flex_cnt_r <= flex_cnt_nxt;
      flex_alm_r <= flex_alm_nxt;
      per_cnt_r  <= per_cnt_nxt;
      cap_cnt_r  <= cap_cnt_nxt;
      cap_frac_r <= cap_frac_nxt;
      st_r       <= st_nxt;
      ien_r      <= ien_nxt;
      wen_r      <= wen_nxt;
      ctrl_r     <= ctrl_nxt;
      for (int i = 0; i < NCH; i++) begin
        scfg_r[i] <= scfg_nxt[i];
        tgt_r[i]  <= tgt_nxt[i];
        per_r[i]  <= per_nxt[i];
        hi_r[i]   <= hi_nxt[i];
      end
      prdata     <= prdata_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
      irq        <= irq_nxt;
      wake       <= wake_nxt;
    end
  end

  // ----------------------------------------------------------------
  // strobe channels, flexible counter only
  // ----------------------------------------------------------------
  // no power-mode input exists here, so only en or flex_en stops the channels
  for (genvar g = 0; g < NCH; g++) begin : gen_strobe
    logic             run_r, run_nxt, out_r, out_nxt;
    logic [PER_W-1:0] ph_r, ph_nxt;
    logic [2:0]       smp_r, smp_nxt, live;

    assign live = sense_s2_r[g*NSENSE +: NSENSE];

    always_comb begin
      run_nxt = run_r;
      ph_nxt  = ph_r;
      smp_nxt = smp_r;
      act_set[g] = 1'b0;
      pat_set[g] = 1'b0;
      if (!scfg_r[g].en || !ctrl_r.flex_en) begin
        run_nxt = 1'b0;
        ph_nxt  = '0;
      end else if (!run_r) begin
        run_nxt = (flex_cnt_r == tgt_r[g]);
        ph_nxt  = '0;
      end else if (flex_src_tick) begin
        ph_nxt = (ph_r >= PER_W'(per_r[g] - PER_W'(1))) ? '0
               : PER_W'(ph_r + PER_W'(1));
      end
      out_nxt = run_nxt & (ph_nxt < hi_r[g]);
      // sample on the falling edge of our own pulse
      if (out_r && !out_nxt) begin
        smp_nxt = live & scfg_r[g].mask;
        act_set[g] = scfg_r[g].act_en
                   & (smp_nxt != smp_r);
        pat_set[g] = scfg_r[g].pat_en
                   & (smp_nxt == (scfg_r[g].pattern
                                  & scfg_r[g].mask));
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        run_r <= 1'b0;
        ph_r  <= '0;
        out_r <= 1'b0;
        smp_r <= '0;
      end else begin
        run_r <= run_nxt;
        ph_r  <= ph_nxt;
        out_r <= out_nxt;
        smp_r <= smp_nxt;
      end
    end

    assign strobe_out[g] = out_r;
  end

endmodule : dual_rtc

/* File: dual_rtc_chk.sv */
`timescale 1ns/1ps
module dual_rtc_chk
  import rtc_pkg::*;
(
  // system
  input wire logic        clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic hole;
  // gap above the last core word, unaligned core words, past the channels
  assign hole = paddr[7] | (paddr[7:6] == 2'h0
                && (paddr > OFS_PER_CNT || paddr[1:0] != 2'h0));
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  sequence rd_s(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  wait_one_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access");
  hole_err_a: assert property (pready && hole |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && !hole |-> !pslverr)
    else $error("mapped access refused");
  idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs busy while idle");
  clear_zero_a: assert property (rd_s(OFS_CLEAR) |-> prdata == 32'h0)
    else $error("clear word reads nonzero");
  per_range_a: assert property (rd_s(OFS_PER_CNT) |-> prdata < 32'd60)
    else $error("periodic count out of range");
  frac_width_a: assert property (
    rd_s(OFS_CAP_FRAC) |-> prdata[31:15] == 17'h0)
    else $error("capture fraction too wide");
endmodule : dual_rtc_chk

bind dual_rtc dual_rtc_chk u_dual_rtc_chk (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr)
);

/* File: rtc_pkg.sv */
package rtc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NCH    = 4;
  localparam int unsigned NSENSE = 3;
  localparam int unsigned NCAP   = 2;
  localparam int unsigned PER_W  = 17;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SEC_CNT   = 8'h04;
  localparam logic [7:0] OFS_SEC_ALM   = 8'h08;
  localparam logic [7:0] OFS_FLEX_CNT  = 8'h0c;
  localparam logic [7:0] OFS_FLEX_ALM  = 8'h10;
  localparam logic [7:0] OFS_CAP_CNT   = 8'h14;
  localparam logic [7:0] OFS_CAP_FRAC  = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_CLEAR     = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h24;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h28;
  localparam logic [7:0] OFS_PER_CNT   = 8'h2c;
  // strobe channels: 8'h40 + 16*ch, sub-registers by word
  localparam logic [1:0] CH_PAGE       = 2'h1;
  localparam logic [1:0] SUB_CFG       = 2'h0;
  localparam logic [1:0] SUB_TARGET    = 2'h1;
  localparam logic [1:0] SUB_PERIOD    = 2'h2;
  localparam logic [1:0] SUB_HIGH      = 2'h3;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_SEC  = 0;
  localparam int unsigned ST_FLEX = 1;
  localparam int unsigned ST_PER  = 2;
  localparam int unsigned ST_CAP  = 3;
  localparam int unsigned ST_ACT  = 4;
  localparam int unsigned ST_PAT  = 8;
  localparam int unsigned ST_W    = 12;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] SEC_DIV_LAST  = 15'h7fff;
  localparam logic [5:0]  PERIODIC_LAST = 6'h3b;
  localparam logic [14:0] FRAC_ALL      = 15'h7fff;
  localparam logic [PER_W-1:0] PERIOD_RST = 17'h00002;
  localparam logic [PER_W-1:0] HIGH_RST   = 17'h00001;

  typedef struct packed {
    logic [3:0] presc_exp;
    logic       cap_en;
    logic       periodic_en;
    logic       flex_alarm_en;
    logic       sec_alarm_en;
    logic       src_osc;
    logic       flex_en;
    logic       sec_en;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] pattern;
    logic [2:0] mask;
    logic       pat_en;
    logic       act_en;
    logic       en;
  } strobe_cfg_type;

  localparam ctrl_type       CTRL_RST = '0;
  localparam strobe_cfg_type SCFG_RST = '0;

endpackage : rtc_pkg

/* File: sensor_model.sv */
`timescale 1ns/1ps
module sensor_model
  import rtc_pkg::*;
(
  // bench commands
  input  wire logic [NCAP-1:0]       fire,
  input  wire logic [NCH*NSENSE-1:0] state,
  // pins
  input  wire logic                  clk,
  input  wire logic [NCH-1:0]        strobe_out,
  output logic      [NCAP-1:0]       cap_in,
  output logic      [NCH*NSENSE-1:0] sense_in
);
  logic [NCH-1:0] seen;
  initial begin
    cap_in = '0;
    sense_in = '0;
    seen = '0;
  end
  // the sensor answers each strobe by publishing its state lines
  always @(posedge clk) begin
    seen <= strobe_out;
    cap_in <= cap_in ^ fire;
    for (int g = 0; g < NCH; g++)
      if (strobe_out[g] && !seen[g])
        sense_in[3*g +: 3] <= state[3*g +: 3];
  end
endmodule : sensor_model

/* File: test_dual_rtc.sv */
`timescale 1ns/1ps
module test_dual_rtc
  import rtc_pkg::*;
;
  logic                  clk, nrst, psel, penable, pwrite, e;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, q, f, v1;
  logic                  pready, pslverr, irq, wake, xtal, osc, s1d;
  logic [NCAP-1:0]       cap_in, fire;
  logic [NCH*NSENSE-1:0] sense_in, state;
  logic [NCH-1:0]        strobe_out;
  int                    num_errors, n_checks, ph, xe, oe, sr, t0, n;
  int                    exps[2] = '{0, 3};

  dual_rtc u_dual_rtc (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_freq_crystal(xtal),
    .low_freq_oscillator(osc), .cap_in(cap_in), .sense_in(sense_in),
    .strobe_out(strobe_out), .irq(irq), .wake(wake)
  );
  sensor_model u_sensor_model (
    .clk(clk), .fire(fire), .state(state), .strobe_out(strobe_out),
    .cap_in(cap_in), .sense_in(sense_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // fast sources keep a full second inside the run budget
  always @(posedge clk) begin
    ph <= ph + 1;
    xtal <= (ph % 2 == 0);
    osc <= (ph % 5 < 2);
    s1d <= strobe_out[1];
    if (strobe_out[1] && !s1d) sr <= sr + 1;
  end
  always @(posedge xtal) xe = xe + 1;
  always @(posedge osc) oe = oe + 1;

  // ----------------------------------------------------------------
  // bus access and comparison
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t no bus answer", $time);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        err;
    apb(1'b1, a, d, r, err);
  endtask : wr

  task automatic near(input logic [31:0] got, input logic [31:0] ex,
                      input logic [31:0] tol, input string m);
    n_checks++;
    if ((got + tol >= ex && got <= ex + tol) !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s got %0h want %0h", $time, m, got, ex);
    end
  endtask : near

  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t no interrupt", $time);
    end
  endtask : wait_irq

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    $display("ERROR %0t timeout", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = '0;
    state = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h58, 32'h0, q, e);
    near(q, 32'(PERIOD_RST), 0, "period rst");
    apb(1'b0, 8'h5c, 32'h0, q, e);
    near(q, 32'(HIGH_RST), 0, "high rst");
    apb(1'b0, 8'h30, 32'h0, q, e);
    near({31'h0, e}, 32'h1, 0, "hole");
    foreach (exps[i]) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FLEX_CNT, 32'h0);
      wr(OFS_CTRL, 32'(exps[i] << 7) | 32'h2);
      t0 = xe;
      repeat (240) @(posedge clk);
      apb(1'b0, OFS_FLEX_CNT, 32'h0, q, e);
      near(q, 32'((xe - t0) >> exps[i]), 2, "prescale");
    end
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FLEX_CNT, 32'h0);
    wr(OFS_CTRL, 32'h6);
    t0 = oe;
    repeat (200) @(posedge clk);
    apb(1'b0, OFS_FLEX_CNT, 32'h0, q, e);
    near(q, 32'(oe - t0), 2, "osc source");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FLEX_CNT, 32'h0);
    wr(OFS_FLEX_ALM, 32'h7);
    wr(OFS_CLEAR, 32'hfff);
    wr(OFS_IRQ_EN, 32'h2);
    wr(OFS_CTRL, 32'h16);
    t0 = oe;
    wait_irq(200);
    near(32'(oe - t0), 32'h7, 1, "flex alarm");
    wr(OFS_CLEAR, 32'hfff);
    @(posedge clk);
    near({31'h0, irq}, 32'h0, 0, "irq clear");
    wr(OFS_IRQ_EN, 32'h4);
    wr(OFS_CTRL, 32'h26);
    wait_irq(400);
    t0 = oe;
    wr(OFS_CLEAR, 32'hfff);
    @(posedge clk);
    wait_irq(400);
    near(32'(oe - t0), 32'd60, 1, "periodic");
    wr(OFS_CTRL, 32'h1c6);
    wr(OFS_CLEAR, 32'hfff);
    wr(OFS_IRQ_EN, 32'h8);
    wr(OFS_WAKE_EN, 32'h8);
    fire <= 2'b01;
    t0 = oe;
    @(posedge clk);
    fire <= 2'b00;
    wait_irq(20);
    near({30'h0, irq, wake}, 32'h3, 0, "capture irq");
    apb(1'b0, OFS_CAP_CNT, 32'h0, q, e);
    apb(1'b0, OFS_CAP_FRAC, 32'h0, f, e);
    v1 = (q << 3) + f;
    repeat (100) @(posedge clk);
    fire <= 2'b10;
    t0 = oe - t0;
    @(posedge clk);
    fire <= 2'b00;
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_CAP_CNT, 32'h0, q, e);
    apb(1'b0, OFS_CAP_FRAC, 32'h0, f, e);
    near((q << 3) + f - v1, 32'(t0), 1, "capture");
    wr(OFS_CTRL, 32'h6);
    wr(OFS_CLEAR, 32'hfff);
    wr(OFS_IRQ_EN, 32'h200);
    state <= 12'h028;
    wr(8'h58, 32'h4);
    wr(8'h5c, 32'h1);
    apb(1'b0, OFS_FLEX_CNT, 32'h0, q, e);
    wr(8'h54, q + 32'd20);
    wr(8'h50, 32'h17f);
    t0 = sr;
    n = 0;
    while (sr == t0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (sr == t0) begin
      num_errors++;
      $display("ERROR %0t no strobe", $time);
    end
    apb(1'b0, OFS_FLEX_CNT, 32'h0, f, e);
    near(f, q + 32'd20, 2, "strobe start");
    t0 = sr;
    n = oe;
    repeat (400) @(posedge clk);
    near(32'(sr - t0), 32'((oe - n) / 4), 1, "strobe rate");
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    near(q & 32'h220, 32'h220, 0, "sense");
    near({31'h0, irq}, 32'h1, 0, "match irq");
    state <= 12'h018;
    repeat (40) @(posedge clk);
    wr(OFS_CLEAR, 32'hfff);
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    near(q & 32'h220, 32'h0, 0, "no match");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_SEC_ALM, 32'h1);
    wr(OFS_CLEAR, 32'hfff);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_WAKE_EN, 32'h1);
    wr(OFS_CTRL, 32'h9);
    t0 = xe;
    wait_irq(70000);
    near(32'(xe - t0), 32'd32768, 3, "one second");
    near({31'h0, wake}, 32'h1, 0, "sec wake");
    apb(1'b0, OFS_SEC_CNT, 32'h0, q, e);
    near(q, 32'h1, 0, "sec count");
    conclude();
  end
endmodule : test_dual_rtc
